/* rtl/dtf_task_port.sv */
// device-side task-file register port with PIO and DMA word stream
`timescale 1ns/1ps
`default_nettype none
module dtf_task_port
  import dtf_pkg::*;
#(
  parameter logic [7:0] CMD_DEV_RESET = 8'h08
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic dd_oe,
  output logic dmarq,
  output logic intrq_out,
  output logic intrq_oe,
  input wire logic dev_strap,
  input wire logic [7:0] status,
  input wire logic core_dmarq,
  input wire logic intr_set,
  input wire logic xfer_to_host,
  input wire logic [15:0] rd_word,
  output logic rd_next,
  output logic [15:0] wr_word,
  output logic wr_valid,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [7:0] prm_cyl_hi,
  output logic [7:0] prm_cyl_lo,
  output logic [7:0] prm_devhead,
  output logic srst,
  output logic nien,
  output logic dev_selected
);
  dtf_acc_if acc ();

  dtf_pin_dec u_dec (
    .clk(clk),
    .nrst(nrst),
    .cs0_n(cs0_n),
    .cs1_n(cs1_n),
    .da(da),
    .dior_n(dior_n),
    .diow_n(diow_n),
    .dmack_n(dmack_n),
    .dd_in(dd_in),
    .acc(acc)
  );

  logic strap_s1;
  logic strap_s2;
  logic strap_taken;
  logic [1:0] strap_age;
  logic my_dev;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] devhead;
  logic int_pend;
  logic bsy;
  logic drq;
  logic wr_cmd_ok;
  logic wr_param_ok;
  logic pio_ok;
  logic dma_ok;
  logic stream_rd;
  logic stream_wr;
  logic answer;
  logic stat_rd_clr;
  logic [15:0] next_dd_out;

  assign bsy = status[ST_BSY_BIT];
  assign drq = status[ST_DRQ_BIT];

  // strap is static on the board; sample it once after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      strap_s1 <= dev_strap;
      strap_s2 <= strap_s1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_age <= 2'h0;
      strap_taken <= 1'b0;
      my_dev <= 1'b0;
    end else if (!strap_taken) begin
      // the synchroniser shows the pin only from the third edge on
      if (strap_age == STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        my_dev <= strap_s2;
      end else begin
        strap_age <= strap_age + 2'h1;
      end
    end
  end

  assign dev_selected = devhead[DH_DEV_BIT] == my_dev;

  // busy blocks parameter writes; of the commands only device reset passes a busy device
  assign wr_param_ok = acc.wr_end && !bsy;
  assign wr_cmd_ok = acc.wr_end && acc.sel == SEL_CMDSTAT
                     && (!bsy || acc.wdata[7:0] == CMD_DEV_RESET);

  // parameter registers, taken by both devices
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyl_lo <= CYL_RST;
    end else if (wr_param_ok && acc.sel == SEL_CYL_LO) begin
      cyl_lo <= acc.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cyl_hi <= CYL_RST;
    end else if (wr_param_ok && acc.sel == SEL_CYL_HI) begin
      cyl_hi <= acc.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      devhead <= DEVHEAD_RST;
    end else if (wr_param_ok && acc.sel == SEL_DEVHEAD) begin
      devhead <= acc.wdata[7:0];
    end
  end

  // device control: acts at once, soft reset reaches both devices
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srst <= 1'b0;
      nien <= 1'b0;
    end else if (acc.wr_end && acc.sel == SEL_CTRLALT) begin
      srst <= acc.wdata[CTL_SRST_BIT];
      nien <= acc.wdata[CTL_NIEN_BIT];
    end
  end

  // command write: start pulse plus parameter snapshot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_start <= 1'b0;
      cmd_code <= CMD_RST;
      prm_cyl_lo <= CYL_RST;
      prm_cyl_hi <= CYL_RST;
      prm_devhead <= DEVHEAD_RST;
    end else begin
      cmd_start <= wr_cmd_ok && dev_selected;
      if (wr_cmd_ok) begin
        cmd_code <= acc.wdata[7:0];
        prm_cyl_lo <= cyl_lo;
        prm_cyl_hi <= cyl_hi;
        prm_devhead <= devhead & ~((8'h01 << DH_OBS_HI_BIT) | (8'h01 << DH_OBS_LO_BIT));
      end
    end
  end

  // status read clears, alternate status read does not; set wins
  assign stat_rd_clr = acc.rd_end && acc.sel == SEL_CMDSTAT && dev_selected;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_pend <= 1'b0;
    end else if (intr_set) begin
      int_pend <= 1'b1;
    end else if (wr_cmd_ok || stat_rd_clr) begin
      int_pend <= 1'b0;
    end
  end

  assign intrq_out = int_pend;
  assign intrq_oe = !nien && dev_selected;

  // PIO and DMA words move only in the active direction
  assign pio_ok = acc.sel == SEL_DATA && drq && !acc.dmack;
  assign dma_ok = acc.sel == SEL_DMA && core_dmarq;
  assign stream_rd = (pio_ok || dma_ok) && xfer_to_host && dev_selected;
  assign stream_wr = (pio_ok || dma_ok) && !xfer_to_host && dev_selected;

  assign dmarq = core_dmarq && dev_selected;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_next <= 1'b0;
    end else begin
      rd_next <= acc.rd_end && dd_oe && stream_rd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_word <= WORD_RST;
    end else begin
      wr_valid <= acc.wr_end && stream_wr;
      if (acc.wr_end && stream_wr) begin
        wr_word <= acc.wdata;
      end
    end
  end

  // read path: answer only when selected and the address is ours
  always_comb begin
    answer = dev_selected;
    next_dd_out = WORD_RST;
    case (acc.sel)
      SEL_DATA: begin
        answer = stream_rd;
        next_dd_out = rd_word;
      end
      SEL_DMA: begin
        answer = stream_rd;
        next_dd_out = rd_word;
      end
      SEL_CYL_LO: next_dd_out = {8'h00, cyl_lo};
      SEL_CYL_HI: next_dd_out = {8'h00, cyl_hi};
      SEL_DEVHEAD: next_dd_out = {8'h00, devhead};
      SEL_CMDSTAT: next_dd_out = {8'h00, status};
      SEL_CTRLALT: next_dd_out = {8'h00, status};
      SEL_NONE: answer = 1'b0;
      default: answer = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dd_oe <= 1'b0;
      dd_out <= WORD_RST;
    end else if (acc.rd_start) begin
      dd_oe <= answer;
      dd_out <= next_dd_out;
    end else if (acc.rd_end) begin
      dd_oe <= 1'b0;
    end
  end

  property p_cmd_clears_int;
    @(posedge clk) disable iff (!nrst)
    wr_cmd_ok && !intr_set |=> !int_pend;
  endproperty
  a_cmd_clears_int: assert property (p_cmd_clears_int)
    else $error("command write left interrupt pending");

  property p_alt_keeps_int;
    @(posedge clk) disable iff (!nrst)
    int_pend && acc.rd_end && acc.sel == SEL_CTRLALT && !wr_cmd_ok |=> int_pend;
  endproperty
  a_alt_keeps_int: assert property (p_alt_keeps_int)
    else $error("alternate status read cleared interrupt");

  property p_alt_eq_status;
    @(posedge clk) disable iff (!nrst)
    acc.rd_start && acc.sel == SEL_CTRLALT && dev_selected
    |=> dd_oe && dd_out == {8'h00, $past(status)};
  endproperty
  a_alt_eq_status: assert property (p_alt_eq_status)
    else $error("alternate status differs from status");

  property p_alt_wr_ctrl;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && acc.sel == SEL_CTRLALT
    |=> nien == $past(acc.wdata[CTL_NIEN_BIT]) && srst == $past(acc.wdata[CTL_SRST_BIT]);
  endproperty
  a_alt_wr_ctrl: assert property (p_alt_wr_ctrl)
    else $error("alternate address write missed device control");

  property p_bsy_blocks;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && bsy && acc.sel == SEL_CYL_LO |=> $stable(cyl_lo);
  endproperty
  a_bsy_blocks: assert property (p_bsy_blocks)
    else $error("parameter write taken while busy");

  property p_cmd_params;
    @(posedge clk) disable iff (!nrst)
    wr_cmd_ok && dev_selected |=> cmd_start && prm_cyl_lo == $past(cyl_lo)
    && prm_cyl_hi == $past(cyl_hi) && cmd_code == $past(acc.wdata[7:0]);
  endproperty
  a_cmd_params: assert property (p_cmd_params)
    else $error("command parameters not captured");

  property p_obs_masked;
    @(posedge clk) disable iff (!nrst)
    cmd_start |-> !prm_devhead[DH_OBS_HI_BIT] && !prm_devhead[DH_OBS_LO_BIT];
  endproperty
  a_obs_masked: assert property (p_obs_masked)
    else $error("obsolete device/head bits passed on");

  property p_nien_floats;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && acc.sel == SEL_CTRLALT && acc.wdata[CTL_NIEN_BIT] |=> !intrq_oe;
  endproperty
  a_nien_floats: assert property (p_nien_floats)
    else $error("interrupt driven while disabled");

  property p_bad_release;
    @(posedge clk) disable iff (!nrst)
    acc.rd_start && acc.sel == SEL_NONE |=> !dd_oe;
  endproperty
  a_bad_release: assert property (p_bad_release)
    else $error("data bus driven on invalid address");

  property p_word_next;
    @(posedge clk) disable iff (!nrst)
    acc.rd_end && dd_oe && stream_rd |=> rd_next ##1 !rd_next;
  endproperty
  a_word_next: assert property (p_word_next)
    else $error("read did not advance the word stream");

  property p_busy_cmd;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && acc.sel == SEL_CMDSTAT && bsy && acc.wdata[7:0] != CMD_DEV_RESET |=> !cmd_start;
  endproperty
  a_busy_cmd: assert property (p_busy_cmd)
    else $error("command started while busy");

  property p_unsel_quiet;
    @(posedge clk) disable iff (!nrst)
    acc.rd_start && !dev_selected |=> !dd_oe;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet)
    else $error("unselected device drove the data bus");

  property p_wr_word;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && stream_wr |=> wr_valid && wr_word == $past(acc.wdata);
  endproperty
  a_wr_word: assert property (p_wr_word)
    else $error("written word not passed on");

  property p_dev_sel;
    @(posedge clk) disable iff (!nrst)
    acc.wr_end && acc.sel == SEL_DEVHEAD && !bsy
    |=> dev_selected == ($past(acc.wdata[DH_DEV_BIT]) == my_dev);
  endproperty
  a_dev_sel: assert property (p_dev_sel)
    else $error("device select bit not effective at write");
endmodule : dtf_task_port
`default_nettype wire

/* rtl/dtf_pkg.sv */
// constants and types shared by the task-file register port
package dtf_pkg;
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_CYL_LO = 3'h4;
  localparam logic [2:0] DA_CYL_HI = 3'h5;
  localparam logic [2:0] DA_DEVHEAD = 3'h6;
  localparam logic [2:0] DA_CMDSTAT = 3'h7;
  localparam logic [2:0] DA_CTRLALT = 3'h6;
  localparam int CTL_SRST_BIT = 2;
  localparam int CTL_NIEN_BIT = 1;
  localparam int DH_DEV_BIT = 4;
  localparam int DH_OBS_HI_BIT = 7;
  localparam int DH_OBS_LO_BIT = 5;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_DRQ_BIT = 3;
  localparam logic [7:0] CYL_RST = 8'h00;
  localparam logic [7:0] DEVHEAD_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [23:0] SYNC_RST = 24'hc7_0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DATA,
    SEL_CYL_LO,
    SEL_CYL_HI,
    SEL_DEVHEAD,
    SEL_CMDSTAT,
    SEL_CTRLALT,
    SEL_DMA
  } dtf_sel_e;
endpackage : dtf_pkg

/* rtl/dtf_acc_if.sv */
// decoded host accesses passed from the pin decoder to the register core
`timescale 1ns/1ps
`default_nettype none
interface dtf_acc_if;
  import dtf_pkg::*;
  dtf_sel_e sel;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic dmack;
  logic [15:0] wdata;
  modport dec (output sel, output rd_start, output rd_end, output wr_end, output dmack,
               output wdata);
  modport core (input sel, input rd_start, input rd_end, input wr_end, input dmack,
                input wdata);
endinterface : dtf_acc_if
`default_nettype wire

/* rtl/dtf_pin_dec.sv */
// pin synchroniser, strobe edge detection and address decode
`timescale 1ns/1ps
`default_nettype none
module dtf_pin_dec
  import dtf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_in,
  dtf_acc_if.dec acc
);
  logic [23:0] sync1;
  logic [23:0] sync2;
  logic dior_q;
  logic diow_q;
  logic s_cs0_n;
  logic s_cs1_n;
  logic [2:0] s_da;
  logic s_dior_n;
  logic s_diow_n;
  logic s_dmack_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, dd_in};
      sync2 <= sync1;
    end
  end

  assign {s_cs0_n, s_cs1_n, s_da, s_dior_n, s_diow_n, s_dmack_n} = sync2[23:16];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dior_q <= 1'b1;
      diow_q <= 1'b1;
    end else begin
      dior_q <= s_dior_n;
      diow_q <= s_diow_n;
    end
  end

  always_comb begin
    acc.sel = SEL_NONE;
    if (!s_cs0_n && s_cs1_n) begin
      case (s_da)
        DA_DATA: acc.sel = SEL_DATA;
        DA_CYL_LO: acc.sel = SEL_CYL_LO;
        DA_CYL_HI: acc.sel = SEL_CYL_HI;
        DA_DEVHEAD: acc.sel = SEL_DEVHEAD;
        DA_CMDSTAT: acc.sel = SEL_CMDSTAT;
        default: acc.sel = SEL_NONE;
      endcase
    end else if (s_cs0_n && !s_cs1_n && s_da == DA_CTRLALT) begin
      acc.sel = SEL_CTRLALT;
    end else if (s_cs0_n && s_cs1_n && !s_dmack_n) begin
      acc.sel = SEL_DMA;
    end
  end

  assign acc.rd_start = dior_q && !s_dior_n;
  assign acc.rd_end = !dior_q && s_dior_n;
  assign acc.wr_end = !diow_q && s_diow_n;
  assign acc.dmack = !s_dmack_n;
  assign acc.wdata = sync2[15:0];
endmodule : dtf_pin_dec
`default_nettype wire

/* dv/dtf_host_bfm.sv */
// host adapter model driving the parallel register port pins
`timescale 1ns/1ps
`default_nettype none
module dtf_host_bfm (
  input wire logic clk,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic dmack_n,
  output logic [15:0] dd_in
);
  initial begin
    {cs1_n, cs0_n, dior_n, diow_n, dmack_n} = 5'h1f;
    da = 3'h0;
    dd_in = 16'ha5a5;
  end

  // cs is {cs1_n, cs0_n}; both negated selects the dma port
  task automatic cyc(input logic [1:0] cs, input logic [2:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] q, output logic oe);
    @(posedge clk);
    #1;
    {cs1_n, cs0_n} = cs;
    da = a;
    dmack_n = ~&cs;
    if (w) begin
      dd_in = d;
    end
    repeat (3) @(posedge clk);
    #1;
    if (w) begin
      diow_n = 1'b0;
    end else begin
      dior_n = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1;
    oe = dd_oe;
    // no sleep mode here, so every answered read counts as valid
    q = dd_out;
    {dior_n, diow_n} = 2'h3;
    repeat (5) @(posedge clk);
    #1;
    {cs1_n, cs0_n, dmack_n} = 3'h7;
    // released bus must not keep showing the last word
    dd_in = ~dd_in;
  endtask : cyc
endmodule : dtf_host_bfm
`default_nettype wire

/* dv/disk_task_file_register_port_test.sv */
// self-checking bench for the task-file register port
`timescale 1ns/1ps
`default_nettype none
module disk_task_file_register_port_test;
  import dtf_pkg::*;
  localparam logic [7:0] RST_CMD = 8'h08;
  localparam logic [1:0] CB = 2'h2;
  localparam logic [1:0] CT = 2'h1;
  localparam logic [1:0] DM = 2'h3;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe, dmarq, intrq_out, intrq_oe, oe;
  logic dev_strap, core_dmarq, intr_set, xfer_to_host, rd_next, wr_valid, cmd_start;
  logic srst, nien, dev_selected;
  logic [2:0] da;
  logic [15:0] dd_in, dd_out, rd_word, wr_word, q, w0;
  logic [7:0] status, cmd_code, prm_cyl_hi, prm_cyl_lo, prm_devhead, n0;
  logic [7:0] ncmd = 8'h00;
  logic [15:0] wq[$];
  int miscompares = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  dtf_task_port #(.CMD_DEV_RESET(RST_CMD)) DUT (.clk, .nrst, .cs0_n, .cs1_n, .da, .dior_n,
    .diow_n, .dmack_n, .dd_in, .dd_out, .dd_oe, .dmarq, .intrq_out, .intrq_oe, .dev_strap,
    .status, .core_dmarq, .intr_set, .xfer_to_host, .rd_word, .rd_next, .wr_word, .wr_valid,
    .cmd_start, .cmd_code, .prm_cyl_hi, .prm_cyl_lo, .prm_devhead, .srst, .nien,
    .dev_selected);

  dtf_host_bfm host (.clk, .dd_out, .dd_oe, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n,
    .dd_in);

  // core side: next word offered after each consumed one
  always @(posedge clk) begin
    #1;
    if (rd_next === 1'b1) begin
      rd_word = rd_word + 16'h0001;
    end
  end

  always @(negedge clk) begin
    if (cmd_start === 1'b1) begin
      ncmd = ncmd + 8'h01;
    end
    if (wr_valid === 1'b1) begin
      wq.push_back(wr_word);
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic acc(input logic [1:0] cs, input logic [2:0] a, input logic w,
                     input logic [15:0] d);
    host.cyc(cs, a, w, d, q, oe);
  endtask : acc

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic t_params();
    chk({14'h0, dev_selected, intrq_oe}, 16'h0003, "after reset");
    acc(CB, DA_CYL_LO, 1'b0, 16'h0000);
    chk(q, 16'h0000, "cyl lo reset");
    acc(CB, DA_CYL_LO, 1'b1, 16'h005a);
    acc(CB, DA_CYL_HI, 1'b1, 16'h00c3);
    acc(CB, DA_DEVHEAD, 1'b1, 16'h00af);
    acc(CB, DA_CYL_HI, 1'b0, 16'h0000);
    chk(q, 16'h00c3, "cyl hi read");
    acc(CB, DA_CMDSTAT, 1'b1, 16'h0020);
    chk({ncmd, cmd_code}, 16'h0120, "command start");
    chk({prm_cyl_hi, prm_cyl_lo}, 16'hc35a, "cylinder params");
    chk({8'h00, prm_devhead}, 16'h000f, "devhead params");
  endtask : t_params

  task automatic t_irq();
    status = 8'h50;
    tick();
    intr_set = 1'b1;
    tick();
    intr_set = 1'b0;
    acc(CT, DA_CTRLALT, 1'b0, 16'h0000);
    chk(q, 16'h0050, "alt status");
    chk({15'h0, intrq_out}, 16'h0001, "alt read keeps irq");
    acc(CB, DA_CMDSTAT, 1'b0, 16'h0000);
    chk(q, 16'h0050, "status at cmd address");
    tick();
    intr_set = 1'b1;
    tick();
    intr_set = 1'b0;
    acc(CB, DA_CMDSTAT, 1'b1, 16'h0021);
    chk({15'h0, intrq_out}, 16'h0000, "cmd clears irq");
  endtask : t_irq

  task automatic t_ctrl();
    acc(CT, DA_CTRLALT, 1'b1, 16'h0002);
    chk({14'h0, nien, intrq_oe}, 16'h0002, "irq disable");
    acc(CT, DA_CTRLALT, 1'b1, 16'h00fc);
    chk({14'h0, srst, nien}, 16'h0002, "soft reset bit");
    acc(CT, DA_CTRLALT, 1'b1, 16'h0000);
    acc(CB, DA_DEVHEAD, 1'b1, 16'h0010);
    chk({14'h0, dev_selected, intrq_oe}, 16'h0000, "unselected");
    acc(CT, DA_CTRLALT, 1'b1, 16'h0004);
    chk({15'h0, srst}, 16'h0001, "reset unselected");
    acc(CT, DA_CTRLALT, 1'b1, 16'h0000);
    n0 = ncmd;
    acc(CB, DA_CMDSTAT, 1'b1, 16'h0020);
    chk({8'h00, ncmd}, {8'h00, n0}, "cmd unselected");
    acc(CB, DA_CYL_LO, 1'b1, 16'h0077);
    acc(CB, DA_CYL_LO, 1'b0, 16'h0000);
    chk({15'h0, oe}, 16'h0000, "read unselected");
    acc(CB, DA_DEVHEAD, 1'b1, 16'h0000);
    acc(CB, DA_CYL_LO, 1'b0, 16'h0000);
    chk(q, 16'h0077, "write taken unselected");
  endtask : t_ctrl

  task automatic t_busy();
    status = 8'h80;
    n0 = ncmd;
    acc(CB, DA_CYL_LO, 1'b1, 16'h0011);
    acc(CB, DA_CMDSTAT, 1'b1, 16'h0020);
    chk({8'h00, ncmd}, {8'h00, n0}, "busy cmd ignored");
    acc(CB, DA_CMDSTAT, 1'b1, {8'h00, RST_CMD});
    chk({ncmd, cmd_code}, {n0 + 8'h01, RST_CMD}, "device reset while busy");
    acc(CT, DA_CTRLALT, 1'b0, 16'h0000);
    chk({15'h0, q[7]}, 16'h0001, "busy bit in alt status");
    status = 8'h00;
    acc(2'h0, DA_CYL_LO, 1'b1, 16'h0033);
    acc(2'h0, DA_CYL_LO, 1'b0, 16'h0000);
    chk({15'h0, oe}, 16'h0000, "both cs");
    acc(CT, DA_CYL_HI, 1'b0, 16'h0000);
    chk({15'h0, oe}, 16'h0000, "cs1 bad address");
    acc(CB, 3'h1, 1'b0, 16'h0000);
    chk({15'h0, oe}, 16'h0000, "cs0 unused address");
    acc(CB, DA_CYL_LO, 1'b0, 16'h0000);
    chk(q, 16'h0077, "busy and bad writes ignored");
  endtask : t_busy

  task automatic t_data();
    status = 8'h08;
    xfer_to_host = 1'b1;
    w0 = rd_word;
    acc(CB, DA_DATA, 1'b0, 16'h0000);
    chk(q, w0, "pio word 0");
    acc(CB, DA_DATA, 1'b0, 16'h0000);
    chk(q, w0 + 16'h0001, "pio word 1");
    acc(CB, DA_DATA, 1'b1, 16'hbeef);
    chk(16'(wq.size()), 16'h0000, "wrong direction");
    xfer_to_host = 1'b0;
    acc(CB, DA_DATA, 1'b1, 16'h1234);
    acc(CB, DA_DATA, 1'b1, 16'h5678);
    status = 8'h00;
    core_dmarq = 1'b1;
    tick();
    chk({15'h0, dmarq}, 16'h0001, "dma request");
    acc(DM, 3'h5, 1'b1, 16'h9abc);
    xfer_to_host = 1'b1;
    w0 = rd_word;
    acc(DM, 3'h2, 1'b0, 16'h0000);
    chk(q, w0, "dma word 0");
    acc(DM, 3'h7, 1'b0, 16'h0000);
    chk(q, w0 + 16'h0001, "dma word 1");
    core_dmarq = 1'b0;
    chk(16'(wq.size()), 16'h0003, "written words");
    chk(wq.pop_front(), 16'h1234, "pio write 0");
    chk(wq.pop_front(), 16'h5678, "pio write 1");
    chk(wq.pop_front(), 16'h9abc, "dma write");
  endtask : t_data

  task automatic t_strap();
    dev_strap = 1'b1;
    nrst = 1'b0;
    repeat (2) tick();
    nrst = 1'b1;
    repeat (4) tick();
    chk({14'h0, dev_selected, intrq_oe}, 16'h0000, "device 1 after reset");
    acc(CB, DA_DEVHEAD, 1'b1, 16'h00b0);
    chk({14'h0, dev_selected, intrq_oe}, 16'h0003, "device 1 selected");
    acc(CB, DA_CYL_LO, 1'b0, 16'h0000);
    chk({oe, 7'h00, q[7:0]}, 16'h8000, "device 1 reads");
  endtask : t_strap

  initial begin
    {dev_strap, core_dmarq, intr_set, xfer_to_host} = 4'h0;
    status = 8'h00;
    rd_word = 16'h1000;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    t_params();
    t_irq();
    t_ctrl();
    t_busy();
    t_data();
    t_strap();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : disk_task_file_register_port_test
`default_nettype wire
